// File: core/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int CNT_W = 10;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 5;
  localparam int WDATA_W = 16;

  // Times in their own units, cycle counts derived from the clock rate
  localparam int TRIG_MIN_NS = 100;
  localparam int ACQ_MIN_NS = 5000;
  localparam int SETTLE_MAX_NS = 2000;
  localparam int BIT_NS = 1000;
  localparam int DUAL_RATE_HZ = 26000;
  localparam int SINGLE_RATE_HZ = 52600;
  localparam logic [CNT_W-1:0] TRIG_CYC = CNT_W'((TRIG_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] ACQ_CYC = CNT_W'((ACQ_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_MAX_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'((BIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] DUAL_PERIOD = CNT_W'((CLK_HZ + DUAL_RATE_HZ - 1) / DUAL_RATE_HZ);
  localparam logic [CNT_W-1:0] SINGLE_PERIOD = CNT_W'((CLK_HZ + SINGLE_RATE_HZ - 1) / SINGLE_RATE_HZ);

  // Result coding selection
  localparam logic [1:0] CODE_STRAIGHT = 2'h0;
  localparam logic [1:0] CODE_OFFSET = 2'h1;
  localparam logic [1:0] CODE_TWOS = 2'h2;

  // Controller register map
  localparam logic [ADDR_W-1:0] CTRL_OFF = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 5'h04;
  localparam logic [ADDR_W-1:0] MASK_OFF = 5'h08;
  localparam logic [ADDR_W-1:0] RESULT0_OFF = 5'h0c;
  localparam logic [ADDR_W-1:0] RESULT1_OFF = 5'h10;
  localparam logic [ADDR_W-1:0] RESULT2_OFF = 5'h14;
  localparam logic [ADDR_W-1:0] RESULT3_OFF = 5'h18;
  localparam int CTRL_GO = 0;
  localparam int CTRL_DUAL = 1;
  localparam int CTRL_PAIR = 2;
  localparam int CTRL_HSEL = 3;
  localparam int CTRL_TIE = 4;
  localparam int CTRL_RUN = 5;
  localparam int EV_W = 2;
  localparam int EV_CONV = 0;
  localparam int EV_CYCLE = 1;
  localparam int ST_BUSY = 8;
  localparam int ST_ACTIVE = 9;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;
endpackage

// File: core/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  import adc_seq_pkg::*;
  logic pairSel;
  logic holdSel;
  logic sampleMode;
  logic trigger;
  logic busy;
  logic [DATA_W-1:0] data;

  modport dev (
    input pairSel,
    input holdSel,
    input sampleMode,
    input trigger,
    output busy,
    output data
  );

  modport host (
    output pairSel,
    output holdSel,
    output sampleMode,
    output trigger,
    input busy,
    input data
  );
endinterface

// File: core/adc_sync2.sv
`timescale 1ns/1ps
module adc_sync2 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic stage1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

// File: core/adc_device.sv
`timescale 1ns/1ps
module adc_device import adc_seq_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  adc_link_if.dev link,
  input wire logic [DATA_W-1:0] in1A,
  input wire logic [DATA_W-1:0] in1B,
  input wire logic [DATA_W-1:0] in2A,
  input wire logic [DATA_W-1:0] in2B,
  input wire logic [1:0] coding
);
  typedef enum logic [1:0] {D_IDLE, D_CONV, D_FINISH, D_END} dev_state_t;

  dev_state_t state;
  logic [DATA_W-1:0] holdA;
  logic [DATA_W-1:0] holdB;
  logic [DATA_W-1:0] target;
  logic [DATA_W-1:0] sar;
  logic [DATA_W-1:0] trial;
  logic [DATA_W-1:0] dataReg;
  logic [3:0] bitIdx;
  logic [CNT_W-1:0] bitCnt;
  logic trigPrev;
  logic trigFall;
  logic busyReg;

  // Both stages track the selected pair while sampling, freeze in hold
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      holdA <= '0;
      holdB <= '0;
    end else if (link.sampleMode) begin
      holdA <= link.pairSel ? in2A : in1A;
      holdB <= link.pairSel ? in2B : in1B;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= link.trigger;
    end
  end

  assign trigFall = trigPrev & ~link.trigger;

  always_comb begin
    trial = sar | DATA_W'(12'h1 << bitIdx);
  end

  // Successive approximation, one bit per divider tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= D_IDLE;
      target <= '0;
      sar <= '0;
      bitIdx <= 4'h0;
      bitCnt <= '0;
      busyReg <= 1'b0;
      dataReg <= '0;
    end else begin
      case (state)
        D_IDLE: begin
          if (trigFall) begin
            target <= link.holdSel ? holdB : holdA;
            sar <= '0;
            bitIdx <= 4'(DATA_W - 1);
            bitCnt <= BIT_CYC - 10'h1;
            busyReg <= 1'b1;
            state <= D_CONV;
          end
        end
        D_CONV: begin
          if (bitCnt == '0) begin
            if (trial <= target) begin
              sar <= trial;
            end
            bitCnt <= BIT_CYC - 10'h1;
            if (bitIdx == 4'h0) begin
              state <= D_FINISH;
            end else begin
              bitIdx <= bitIdx - 4'h1;
            end
          end else begin
            bitCnt <= bitCnt - 10'h1;
          end
        end
        D_FINISH: begin
          // Result settles one cycle before the end-of-conversion edge
          if (coding == CODE_TWOS) begin
            dataReg <= {~sar[DATA_W-1], sar[DATA_W-2:0]};
          end else begin
            dataReg <= sar;
          end
          state <= D_END;
        end
        D_END: begin
          busyReg <= 1'b0;
          state <= D_IDLE;
        end
        default: begin
          state <= D_IDLE;
        end
      endcase
    end
  end

  // Output word changes only at the end of a conversion
  assign link.data = dataReg;
  assign link.busy = busyReg;
endmodule

// File: core/adc_host.sv
`timescale 1ns/1ps
module adc_host import adc_seq_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  adc_link_if.host link,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WDATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [WDATA_W-1:0] rdata,
  output logic irq
);
  typedef enum logic [2:0] {H_IDLE, H_GAP, H_ACQ, H_PULSE, H_RISE, H_FALL, H_SETTLE} host_state_t;

  host_state_t state;
  logic dual;
  logic pairCfg;
  logic hselCfg;
  logic tie;
  logic run;
  logic goPend;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] statusClr;
  logic [DATA_W-1:0] results [4];
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] rateCnt;
  logic pairReg;
  logic holdReg;
  logic modeReg;
  logic trigReg;
  logic secondPair;
  logic busySync;
  logic tieEff;
  logic convDone;
  logic startCycle;

  adc_sync2 busySyncU (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(link.busy),
    .q(busySync)
  );

  // Shared line only in single-channel mode: dual needs a second pulse in hold
  assign tieEff = tie & ~dual;
  assign link.pairSel = pairReg;
  assign link.holdSel = holdReg;
  assign link.sampleMode = modeReg;
  assign link.trigger = tieEff ? modeReg : trigReg;
  assign convDone = (state == H_FALL) && !busySync;
  assign startCycle = (state == H_GAP) && (rateCnt == '0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dual <= 1'b0;
      pairCfg <= 1'b0;
      hselCfg <= 1'b0;
      tie <= 1'b0;
      run <= 1'b0;
    end else if (wr && addr == CTRL_OFF) begin
      dual <= wdata[CTRL_DUAL];
      pairCfg <= wdata[CTRL_PAIR];
      hselCfg <= wdata[CTRL_HSEL];
      tie <= wdata[CTRL_TIE];
      run <= wdata[CTRL_RUN];
    end
  end

  // Start request: a new request wins over the acceptance clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      goPend <= 1'b0;
    end else if (wr && addr == CTRL_OFF && wdata[CTRL_GO]) begin
      goPend <= 1'b1;
    end else if (state == H_IDLE) begin
      goPend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask <= MASK_RST;
    end else if (wr && addr == MASK_OFF) begin
      mask <= wdata[EV_W-1:0];
    end
  end

  // Spacing between the starts of two sampling cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rateCnt <= '0;
    end else if (startCycle) begin
      rateCnt <= (dual ? DUAL_PERIOD : SINGLE_PERIOD) - 10'h1;
    end else if (rateCnt != '0) begin
      rateCnt <= rateCnt - 10'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= H_IDLE;
      timer <= '0;
      pairReg <= 1'b0;
      holdReg <= 1'b0;
      modeReg <= 1'b1;
      trigReg <= 1'b0;
      secondPair <= 1'b0;
    end else begin
      case (state)
        H_IDLE: begin
          modeReg <= 1'b1;
          if (goPend || run) begin
            pairReg <= pairCfg;
            holdReg <= dual ? 1'b0 : hselCfg;
            secondPair <= 1'b0;
            state <= H_GAP;
          end
        end
        H_GAP: begin
          modeReg <= 1'b1;
          if (rateCnt == '0) begin
            timer <= SETTLE_CYC + ACQ_CYC;
            state <= H_ACQ;
          end
        end
        H_ACQ: begin
          if (timer == '0) begin
            modeReg <= 1'b0;
            trigReg <= ~tieEff;
            timer <= TRIG_CYC - 10'h1;
            state <= H_PULSE;
          end else begin
            timer <= timer - 10'h1;
          end
        end
        H_PULSE: begin
          if (timer == '0) begin
            trigReg <= 1'b0;
            state <= H_RISE;
          end else begin
            timer <= timer - 10'h1;
          end
        end
        H_RISE: begin
          if (busySync) begin
            state <= H_FALL;
          end
        end
        H_FALL: begin
          if (!busySync) begin
            if (dual && !holdReg) begin
              holdReg <= 1'b1;
              timer <= SETTLE_CYC;
              state <= H_SETTLE;
            end else begin
              modeReg <= 1'b1;
              holdReg <= dual ? 1'b0 : holdReg;
              if (dual && !secondPair) begin
                pairReg <= ~pairReg;
                secondPair <= 1'b1;
                state <= H_GAP;
              end else begin
                state <= H_IDLE;
              end
            end
          end
        end
        H_SETTLE: begin
          if (timer == '0) begin
            trigReg <= 1'b1;
            timer <= TRIG_CYC - 10'h1;
            state <= H_PULSE;
          end else begin
            timer <= timer - 10'h1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // Result word taken once the synchronised busy has fallen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        results[i] <= '0;
      end
    end else if (convDone) begin
      results[{pairReg, holdReg}] <= link.data;
    end
  end

  always_comb begin
    events = '0;
    events[EV_CONV] = convDone;
    events[EV_CYCLE] = convDone && !(dual && !holdReg) && !(dual && !secondPair);
    statusClr = (rd && addr == STATUS_OFF) ? {EV_W{1'b1}} : '0;
  end

  // Sticky events: read clears, a same-cycle event survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= EV_RST;
    end else begin
      status <= (status & ~statusClr) | events;
    end
  end

  assign irq = |(status & mask);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        CTRL_OFF: rdata <= {10'h0, run, tie, hselCfg, pairCfg, dual, goPend};
        STATUS_OFF: rdata <= {6'h0, state != H_IDLE, busySync, 6'h0, status};
        MASK_OFF: rdata <= {14'h0, mask};
        RESULT0_OFF: rdata <= {4'h0, results[0]};
        RESULT1_OFF: rdata <= {4'h0, results[1]};
        RESULT2_OFF: rdata <= {4'h0, results[2]};
        RESULT3_OFF: rdata <= {4'h0, results[3]};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

// File: tb/adc_seq_sva.sv
`timescale 1ns/1ps
module adc_seq_sva import adc_seq_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pairSel,
  input wire logic holdSel,
  input wire logic sampleMode,
  input wire logic trigger,
  input wire logic busy,
  input wire logic [DATA_W-1:0] data
);
  int busyCnt;
  int sampCnt;
  int selCnt;
  int fallCnt;
  always_ff @(posedge ref_clk) begin
    busyCnt <= (rst || !busy) ? 0 : busyCnt + 1;
  end
  always_ff @(posedge ref_clk) begin
    sampCnt <= (rst || !sampleMode) ? 0 : ((sampCnt < 1000) ? sampCnt + 1 : sampCnt);
  end
  // Cycles since either select line last moved
  always_ff @(posedge ref_clk) begin
    selCnt <= (rst || $changed(pairSel) || $changed(holdSel)) ? 0 : ((selCnt < 1000) ? selCnt + 1 : selCnt);
  end
  // Cycles since the mode line last fell, parked high after reset
  always_ff @(posedge ref_clk) begin
    fallCnt <= rst ? 1000 : ($fell(sampleMode) ? 0 : ((fallCnt < 1000) ? fallCnt + 1 : fallCnt));
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_trigFall;
    $fell(trigger) ##0 !busy;
  endsequence
  sequence s_dataLoad;
    busy ##1 !busy;
  endsequence
  property p_busyStart;
    s_trigFall |=> busy;
  endproperty
  a_busyStart: assert property (p_busyStart) else $error("busy did not rise after trigger fall");
  property p_busyLen;
    $fell(busy) |-> busyCnt >= 240 && busyCnt <= 243;
  endproperty
  a_busyLen: assert property (p_busyLen) else $error("busy length wrong");
  property p_trigIdle;
    $fell(trigger) |-> !busy;
  endproperty
  a_trigIdle: assert property (p_trigIdle) else $error("trigger during conversion");
  property p_dataWhen;
    $changed(data) |-> s_dataLoad;
  endproperty
  a_dataWhen: assert property (p_dataWhen) else $error("data moved outside conversion end");
  property p_holdBusy;
    busy |-> !sampleMode;
  endproperty
  a_holdBusy: assert property (p_holdBusy) else $error("sampling during conversion");
  property p_acq;
    $fell(sampleMode) |-> sampCnt >= ACQ_CYC;
  endproperty
  a_acq: assert property (p_acq) else $error("sample phase too short");
  property p_trigWidth;
    $fell(trigger) |-> $past(trigger, 2);
  endproperty
  a_trigWidth: assert property (p_trigWidth) else $error("trigger pulse too short");
  property p_settle;
    $fell(trigger) |-> selCnt >= SETTLE_CYC;
  endproperty
  a_settle: assert property (p_settle) else $error("select not settled at trigger");
  property p_rate;
    $fell(sampleMode) |-> fallCnt >= SINGLE_PERIOD - 10'h1;
  endproperty
  a_rate: assert property (p_rate) else $error("sampling cycles too close together");
endmodule

// File: tb/dual_sample_hold_adc_sequencer_test.sv
`timescale 1ns/1ps
module dual_sample_hold_adc_sequencer_test;
  import adc_seq_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  logic wr = 0;
  logic rd = 0;
  logic rdLate = 0;
  logic irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [WDATA_W-1:0] wdata = '0;
  logic [WDATA_W-1:0] rdata;
  logic [WDATA_W-1:0] lastRd = '0;
  logic [DATA_W-1:0] in1A = '0, in1B = '0, in2A = '0, in2B = '0, expData;
  logic [1:0] coding = 2'h0;
  logic [31:0] expQ[$];
  logic [31:0] expEntry;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  adc_link_if link();
  adc_device adc_device_inst(.ref_clk(ref_clk), .rst(rst), .link(link), .in1A(in1A), .in1B(in1B),
    .in2A(in2A), .in2B(in2B), .coding(coding));
  adc_host adc_host_inst(.ref_clk(ref_clk), .rst(rst), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  adc_seq_sva adc_seq_sva_inst(.ref_clk(ref_clk), .rst(rst), .pairSel(link.pairSel), .holdSel(link.holdSel),
    .sampleMode(link.sampleMode), .trigger(link.trigger), .busy(link.busy), .data(link.data));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    rdLate <= rd;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  // Read checker: oldest note against the answer cycle
  always @(negedge ref_clk) begin
    if (rdLate) begin
      lastRd = rdata;
      expEntry = expQ.pop_front();
      if (expEntry[31:16] != 16'h0) begin
        chk("rdata", expEntry[15:0], rdata & expEntry[31:16]);
      end
    end
  end
  task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [WDATA_W-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
    expQ.push_back({m, e});
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    #1;
  endtask
  task automatic waitBit(input int b);
    int n;
    n = 0;
    lastRd = '0;
    while (lastRd[b] !== 1'b1 && n < 1000) begin
      rdReg(STATUS_OFF, 16'h0, 16'h0);
      n++;
    end
    chk("status", 16'h1 << b, lastRd & (16'h1 << b));
  endtask
  task automatic newIn();
    @(posedge ref_clk);
    in1A <= DATA_W'($urandom());
    in1B <= DATA_W'($urandom());
    in2A <= DATA_W'($urandom());
    in2B <= DATA_W'($urandom());
  endtask
  function automatic logic [DATA_W-1:0] enc(input logic [DATA_W-1:0] v);
    return (coding == CODE_TWOS) ? {~v[DATA_W-1], v[DATA_W-2:0]} : v;
  endfunction
  function automatic logic [DATA_W-1:0] pick(input int i);
    return (i == 0) ? in1A : (i == 1) ? in1B : (i == 2) ? in2A : in2B;
  endfunction
  task automatic runSingle(input int i);
    logic [15:0] ctl;
    newIn();
    coding <= 2'(i % 3);
    ctl = 16'h1 | (16'({i[0], i[1]}) << CTRL_PAIR);
    if (i > 3) begin
      ctl[CTRL_TIE] = 1'b1;
    end
    wrReg(CTRL_OFF, ctl);
    waitBit(EV_CONV);
    expData = enc(pick(i % 4));
    chk("data", expData, link.data);
    chk("pairSel", 16'(i[1]), link.pairSel);
    chk("holdSel", 16'(i[0]), link.holdSel);
    newIn();
    repeat (5) @(posedge ref_clk);
    #1;
    chk("held data", expData, link.data);
    rdReg(RESULT0_OFF + ADDR_W'(4 * (i % 4)), 16'hfff, 16'(expData));
  endtask
  initial begin
    int i;
    int n;
    i = $urandom(32'h3cb8);
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("sampleMode", 16'h1, 16'(link.sampleMode));
    chk("busy", 16'h0, 16'(link.busy));
    chk("irq", 16'h0, 16'(irq));
    rdReg(MASK_OFF, 16'h3, 16'h0);
    rdReg(5'h1c, 16'hffff, 16'h0);
    for (i = 0; i < 4; i++) begin
      runSingle(i);
    end
    wrReg(MASK_OFF, 16'h1);
    wrReg(CTRL_OFF, 16'h1);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    chk("irq", 16'h1, 16'(irq));
    rdReg(STATUS_OFF, 16'h3, 16'h3);
    chk("irq", 16'h0, 16'(irq));
    newIn();
    wrReg(CTRL_OFF, 16'h7);
    waitBit(EV_CYCLE);
    rdReg(RESULT2_OFF, 16'hfff, 16'(enc(in2A)));
    rdReg(RESULT3_OFF, 16'hfff, 16'(enc(in2B)));
    rdReg(RESULT0_OFF, 16'hfff, 16'(enc(in1A)));
    rdReg(RESULT1_OFF, 16'hfff, 16'(enc(in1B)));
    // Continuous mode: two cycles without a go, then stop and let the last one finish
    newIn();
    wrReg(CTRL_OFF, 16'h20);
    waitBit(EV_CYCLE);
    waitBit(EV_CYCLE);
    wrReg(CTRL_OFF, 16'h0);
    waitBit(EV_CYCLE);
    chk("data", 16'(enc(in1A)), link.data);
    rdReg(STATUS_OFF, 16'h200, 16'h0);
    rdReg(RESULT0_OFF, 16'hfff, 16'(enc(in1A)));
    for (i = 4; i < 7; i++) begin
      runSingle(i);
    end
    end_sim();
  end
endmodule
